// ===== cres_pkg.sv
// Constants and types shared by the receive error status block.
// Assumes a single 20 MHz clock and a plain register port.
package cres_pkg;

  localparam logic [7:0]  CRES_ADDR_ERR_STATUS = 8'h06;
  localparam logic [31:0] CRES_RESET_VALUE     = 32'h0000_0000;
  localparam logic [7:0]  CRES_PAYLOAD_LIMIT   = 8'h1C;

  // Bit positions of the status word
  localparam int CRES_B_DIST_ANY   = 29;
  localparam int CRES_B_DIST_PHY   = 28;
  localparam int CRES_B_MINLEN     = 27;
  localparam int CRES_B_LE_CRC     = 26;
  localparam int CRES_B_SHORT_CHAR = 25;
  localparam int CRES_B_NO_PARITY  = 24;
  localparam int CRES_B_NO_STOP    = 23;
  localparam int CRES_B_COLL_PAR   = 22;
  localparam int CRES_B_COLL_STOP  = 21;
  localparam int CRES_B_COLL       = 18;
  localparam int CRES_B_RXOVER     = 17;
  localparam int CRES_B_FIELD      = 16;
  localparam int CRES_B_ERR        = 15;
  localparam int CRES_B_BYTECNT    = 14;
  localparam int CRES_B_INVPAR     = 13;
  localparam int CRES_B_PATTERN    = 12;
  localparam int CRES_B_ANTICOLL   = 11;
  localparam int CRES_B_CRC        = 10;
  localparam int CRES_B_LEN        = 9;
  localparam int CRES_B_PHY        = 8;
  localparam int CRES_B_PARITY     = 7;
  localparam int CRES_B_STOPBIT    = 6;
  localparam int CRES_B_WRITE      = 5;
  localparam int CRES_B_OVFL       = 4;
  localparam int CRES_B_LATENCY    = 3;
  localparam int CRES_B_INTEGRITY  = 2;
  localparam int CRES_B_PROTOCOL   = 1;
  localparam int CRES_B_ANY        = 0;

  // Reception protocol family of the frame in progress
  typedef enum logic [2:0] {
    CRES_P_A106, CRES_P_A_FAST, CRES_P_B, CRES_P_LENFIELD, CRES_P_OTHER
  } cres_proto_t;

endpackage

// ===== cres_ev_if.sv
// Event bundle between the receiver datapath side and the flag store.
// Assumes one clock; every event is a one-cycle pulse.
interface cres_ev_if;
  logic        frame_start;
  logic [31:0] set_mask;
  logic [31:0] flags;
  modport src (output frame_start, output set_mask, input flags);
  modport dst (input frame_start, input set_mask, output flags);
endinterface

// ===== cres_flags.sv
// Sticky flag store for the receive error status word.
// Assumes events and frame start are synchronous pulses.
module cres_flags
  import cres_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Events
  cres_ev_if.dst   ev
);

  typedef struct packed {
    logic [W-1:0] flags;
  } cres_fl_st_t;

  cres_fl_st_t s_q;
  cres_fl_st_t s_d;

  // Events of the start cycle belong to the new frame, so set beats clear
  always_comb begin
    s_d = s_q;
    if (ev.frame_start) begin
      s_d.flags = ev.set_mask;
    end else begin
      s_d.flags = s_q.flags | ev.set_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.flags <= W'(CRES_RESET_VALUE);
    end else begin
      s_q <= s_d;
    end
  end

  assign ev.flags = s_q.flags;

  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    (!$past(ev.frame_start) && !$past(rst)) |-> ((ev.flags & $past(ev.flags)) == $past(ev.flags)))
    else $error("flag dropped without frame start");

endmodule

// ===== cres_top.sv
// Receive error status register of the contactless front end.
// Assumes datapath events are one-cycle synchronous pulses.
module cres_top
  import cres_pkg::*;
#(
  parameter logic [7:0] PAYLOAD_LIMIT = CRES_PAYLOAD_LIMIT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Frame context
  input  wire logic        frame_start,
  input  wire cres_proto_t proto,
  input  wire logic        poll_req_reader,
  // Disturbance detections
  input  wire logic        dist_phy,
  input  wire logic        dist_decoder,
  // Length and character checks
  input  wire logic        len_below_floor,
  input  wire logic        len_le_crc,
  input  wire logic        last_char_short,
  input  wire logic        last_char_no_parity,
  input  wire logic        last_char_no_stop,
  // Collisions
  input  wire logic        coll_parity_pos,
  input  wire logic        coll_stop_pos,
  input  wire logic        coll_data_pos,
  // Stop causes
  input  wire logic        rxover_msg,
  input  wire logic        field_lost,
  input  wire logic        comm_err_abort,
  input  wire logic        byte_count_done,
  input  wire logic        inverted_parity,
  input  wire logic        eof_pattern,
  // Integrity and framing checks
  input  wire logic        crc_bad,
  input  wire logic        len_short_of_field,
  input  wire logic        len_field_out_of_range,
  input  wire logic        phy_comm_err,
  input  wire logic        parity_mismatch,
  input  wire logic        stop_bit_low,
  // System RAM writer
  input  wire logic        ram_err_ack,
  input  wire logic        ram_congestion,
  input  wire logic        payload_byte,
  // Reception end
  output logic             rx_stop
);

  typedef struct packed {
    logic [31:0] rdata;
    logic [7:0]  payload_cnt;
    logic        busy;
  } cres_st_t;

  cres_st_t    s_q;
  cres_st_t    s_d;
  logic [31:0] ev;
  logic        any_coll;
  logic        stop_len;
  logic        stop_inv;
  logic        stop_eof;
  logic        stop_acoll;
  logic        integrity;
  logic        protocol;
  logic        ovfl;

  cres_ev_if bus_if ();

  // ------------------------------------------------------------
  // Event qualification
  // ------------------------------------------------------------
  assign any_coll   = coll_parity_pos | coll_stop_pos | coll_data_pos;
  assign stop_len   = byte_count_done & (proto == CRES_P_LENFIELD);
  assign stop_inv   = inverted_parity & (proto == CRES_P_A_FAST);
  assign stop_eof   = eof_pattern & (proto == CRES_P_B);
  assign stop_acoll = coll_data_pos & (proto == CRES_P_A106);
  // Overflow counts only in the reader poll procedure
  assign ovfl = poll_req_reader & (proto == CRES_P_LENFIELD) & payload_byte
              & (s_q.payload_cnt >= PAYLOAD_LIMIT);
  assign integrity = parity_mismatch | crc_bad;
  assign protocol  = stop_bit_low | last_char_no_parity | last_char_short
                   | last_char_no_stop | len_below_floor | len_le_crc;

  always_comb begin
    ev = '0;
    ev[CRES_B_DIST_ANY]   = dist_phy | dist_decoder;
    ev[CRES_B_DIST_PHY]   = dist_phy;
    ev[CRES_B_MINLEN]     = len_below_floor;
    ev[CRES_B_LE_CRC]     = len_le_crc;
    ev[CRES_B_SHORT_CHAR] = last_char_short;
    ev[CRES_B_NO_PARITY]  = last_char_no_parity;
    ev[CRES_B_NO_STOP]    = last_char_no_stop;
    ev[CRES_B_COLL_PAR]   = coll_parity_pos;
    ev[CRES_B_COLL_STOP]  = coll_stop_pos;
    ev[CRES_B_COLL]       = any_coll;
    ev[CRES_B_RXOVER]     = rxover_msg;
    ev[CRES_B_FIELD]      = field_lost;
    ev[CRES_B_ERR]        = comm_err_abort;
    ev[CRES_B_BYTECNT]    = stop_len;
    ev[CRES_B_INVPAR]     = stop_inv;
    ev[CRES_B_PATTERN]    = stop_eof;
    ev[CRES_B_ANTICOLL]   = stop_acoll;
    ev[CRES_B_CRC]        = crc_bad;
    ev[CRES_B_LEN]        = (len_short_of_field | len_field_out_of_range)
                          & (proto == CRES_P_LENFIELD);
    ev[CRES_B_PHY]        = phy_comm_err;
    ev[CRES_B_PARITY]     = parity_mismatch;
    ev[CRES_B_STOPBIT]    = stop_bit_low;
    ev[CRES_B_WRITE]      = ram_err_ack;
    ev[CRES_B_OVFL]       = ovfl;
    ev[CRES_B_LATENCY]    = ram_congestion;
    ev[CRES_B_INTEGRITY]  = integrity;
    ev[CRES_B_PROTOCOL]   = protocol;
    ev[CRES_B_ANY]        = integrity | protocol;
  end

  assign bus_if.frame_start = frame_start;
  assign bus_if.set_mask    = ev;

  cres_flags #(
    .W (32)
  ) u_flags (
    .clk (clk),
    .rst (rst),
    .ev  (bus_if)
  );

  // ------------------------------------------------------------
  // Reception end, payload counter and read port
  // ------------------------------------------------------------
  // Any stop cause ends the frame in progress
  assign rx_stop = s_q.busy & (rxover_msg | field_lost | comm_err_abort
                 | stop_len | stop_inv | stop_eof | stop_acoll);

  always_comb begin
    s_d = s_q;
    if (frame_start) begin
      s_d.busy        = 1'b1;
      s_d.payload_cnt = '0;
    end else if (rx_stop) begin
      s_d.busy = 1'b0;
    end
    if (!frame_start && payload_byte && s_q.payload_cnt != 8'hFF) begin
      s_d.payload_cnt = s_q.payload_cnt + 8'h01;
    end
    // Register is read-only; writes are ignored, reads have no side effect
    s_d.rdata = '0;
    if (reg_rd && reg_addr == CRES_ADDR_ERR_STATUS) begin
      s_d.rdata = bus_if.flags;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence seq_read_status;
    reg_rd && reg_addr == CRES_ADDR_ERR_STATUS;
  endsequence

  AST_DIST_ANY: assert property (@(posedge clk) disable iff (rst)
    (dist_decoder && !rst) |=> bus_if.flags[CRES_B_DIST_ANY])
    else $error("combined disturbance flag not set");
  AST_DIST_PHY: assert property (@(posedge clk) disable iff (rst)
    (frame_start && !dist_phy) |=> !bus_if.flags[CRES_B_DIST_PHY])
    else $error("physical disturbance flag set without cause");
  AST_COLL: assert property (@(posedge clk) disable iff (rst)
    (coll_parity_pos || coll_stop_pos) |=> bus_if.flags[CRES_B_COLL])
    else $error("collision flag missing");
  AST_LEN_GATE: assert property (@(posedge clk) disable iff (rst)
    (frame_start && proto != CRES_P_LENFIELD) |=> !bus_if.flags[CRES_B_LEN])
    else $error("length fault outside length-field protocol");
  AST_ANTICOLL: assert property (@(posedge clk) disable iff (rst)
    (coll_data_pos && proto == CRES_P_A106 && s_q.busy) |-> rx_stop ##1
    bus_if.flags[CRES_B_ANTICOLL])
    else $error("anticollision stop missing");
  AST_ANY: assert property (@(posedge clk) disable iff (rst)
    (stop_bit_low || last_char_no_parity || last_char_short)
    |=> bus_if.flags[CRES_B_PROTOCOL] && bus_if.flags[CRES_B_ANY])
    else $error("overall error flag missing");
  AST_CRC: assert property (@(posedge clk) disable iff (rst)
    crc_bad |=> bus_if.flags[CRES_B_CRC] && bus_if.flags[CRES_B_INTEGRITY])
    else $error("crc flags not set");
  AST_READ: assert property (@(posedge clk) disable iff (rst)
    seq_read_status |=> reg_rdata == $past(bus_if.flags))
    else $error("read data does not match flags");
  // Writes must never leave anything on the read port
  AST_WR_QUIET: assert property (@(posedge clk) disable iff (rst)
    reg_wr |=> reg_rdata == 32'h0000_0000)
    else $error("write produced read data");
  AST_RXOVER: assert property (@(posedge clk) disable iff (rst)
    rxover_msg |=> bus_if.flags[CRES_B_RXOVER])
    else $error("receive-over stop flag missing");
  AST_FIELD: assert property (@(posedge clk) disable iff (rst)
    field_lost |=> bus_if.flags[CRES_B_FIELD])
    else $error("field loss stop flag missing");
  AST_BYTECNT: assert property (@(posedge clk) disable iff (rst)
    (byte_count_done && proto == CRES_P_LENFIELD) |=> bus_if.flags[CRES_B_BYTECNT])
    else $error("byte count stop flag missing");
  AST_INVPAR: assert property (@(posedge clk) disable iff (rst)
    (inverted_parity && proto == CRES_P_A_FAST) |=> bus_if.flags[CRES_B_INVPAR])
    else $error("inverted parity stop flag missing");
  AST_PATTERN: assert property (@(posedge clk) disable iff (rst)
    (eof_pattern && proto == CRES_P_B) |=> bus_if.flags[CRES_B_PATTERN])
    else $error("end pattern stop flag missing");
  AST_OVFL_CLR: assert property (@(posedge clk) disable iff (rst)
    (frame_start && !payload_byte) |=> !bus_if.flags[CRES_B_OVFL])
    else $error("overflow flag survived frame start");

endmodule

// ===== cres_top_tb.sv
// Self-checking bench for the receive error status register.
// Assumes cres_pkg and cres_top are compiled first; one 20 MHz clock.
module cres_top_tb
  import cres_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [4:0]  idx;
    cres_proto_t proto;
    logic [31:0] exp;
  } cres_row_t;

  logic        clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        frame_start;
  cres_proto_t proto;
  logic        poll_req_reader;
  logic [24:0] ev;
  logic        rx_stop;
  int          error_cnt;
  int          compares;

  // ----------------------------------------
  // Ordinary cases: event index, protocol, flags
  // ----------------------------------------
  cres_row_t rows [29] = '{
    '{5'h00, CRES_P_OTHER, 32'h3000_0000}, '{5'h01, CRES_P_OTHER, 32'h2000_0000},
    '{5'h02, CRES_P_OTHER, 32'h0800_0003}, '{5'h03, CRES_P_OTHER, 32'h0400_0003},
    '{5'h04, CRES_P_OTHER, 32'h0200_0003}, '{5'h05, CRES_P_OTHER, 32'h0100_0003},
    '{5'h06, CRES_P_OTHER, 32'h0080_0003}, '{5'h07, CRES_P_OTHER, 32'h0044_0000},
    '{5'h08, CRES_P_OTHER, 32'h0024_0000}, '{5'h09, CRES_P_A106, 32'h0004_0800},
    '{5'h0A, CRES_P_OTHER, 32'h0002_0000}, '{5'h0B, CRES_P_OTHER, 32'h0001_0000},
    '{5'h0C, CRES_P_OTHER, 32'h0000_8000}, '{5'h0D, CRES_P_LENFIELD, 32'h0000_4000},
    '{5'h0E, CRES_P_A_FAST, 32'h0000_2000}, '{5'h0F, CRES_P_B, 32'h0000_1000},
    '{5'h10, CRES_P_OTHER, 32'h0000_0405}, '{5'h11, CRES_P_LENFIELD, 32'h0000_0200},
    '{5'h12, CRES_P_LENFIELD, 32'h0000_0200}, '{5'h13, CRES_P_OTHER, 32'h0000_0100},
    '{5'h14, CRES_P_OTHER, 32'h0000_0085}, '{5'h15, CRES_P_OTHER, 32'h0000_0043},
    '{5'h16, CRES_P_OTHER, 32'h0000_0020}, '{5'h17, CRES_P_OTHER, 32'h0000_0008},
    // Stop causes and length fault outside their protocol stay clear
    '{5'h0D, CRES_P_OTHER, 32'h0000_0000}, '{5'h0E, CRES_P_A106, 32'h0000_0000},
    '{5'h0F, CRES_P_A_FAST, 32'h0000_0000}, '{5'h09, CRES_P_B, 32'h0004_0000},
    '{5'h11, CRES_P_A106, 32'h0000_0000}
  };

  cres_top cres_top_inst (
    .clk                    (clk),
    .rst                    (rst),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .frame_start            (frame_start),
    .proto                  (proto),
    .poll_req_reader        (poll_req_reader),
    .dist_phy               (ev[0]),
    .dist_decoder           (ev[1]),
    .len_below_floor        (ev[2]),
    .len_le_crc             (ev[3]),
    .last_char_short        (ev[4]),
    .last_char_no_parity    (ev[5]),
    .last_char_no_stop      (ev[6]),
    .coll_parity_pos        (ev[7]),
    .coll_stop_pos          (ev[8]),
    .coll_data_pos          (ev[9]),
    .rxover_msg             (ev[10]),
    .field_lost             (ev[11]),
    .comm_err_abort         (ev[12]),
    .byte_count_done        (ev[13]),
    .inverted_parity        (ev[14]),
    .eof_pattern            (ev[15]),
    .crc_bad                (ev[16]),
    .len_short_of_field     (ev[17]),
    .len_field_out_of_range (ev[18]),
    .phy_comm_err           (ev[19]),
    .parity_mismatch        (ev[20]),
    .stop_bit_low           (ev[21]),
    .ram_err_ack            (ev[22]),
    .ram_congestion         (ev[23]),
    .payload_byte           (ev[24]),
    .rx_stop                (rx_stop)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pulse(input logic [24:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= '0;
  endtask

  task automatic start_frame(input cres_proto_t p, input logic [24:0] m);
    @(posedge clk);
    proto       <= p;
    frame_start <= 1'b1;
    ev          <= m;
    @(posedge clk);
    frame_start <= 1'b0;
    ev          <= '0;
  endtask

  // Data stand only in the cycle after the strobe, then drop to zero
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(what, reg_rdata, exp);
    @(negedge clk);
    check("rdata idle", reg_rdata, 32'h0000_0000);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    compares = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_start = 1'b0;
    proto = CRES_P_OTHER;
    poll_req_reader = 1'b0;
    ev = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0000_0000, "reset value");
    foreach (rows[i]) begin
      start_frame(rows[i].proto, '0);
      pulse(25'h1 << rows[i].idx);
      rd_chk(CRES_ADDR_ERR_STATUS, rows[i].exp, "flags");
    end
    // Flags gather within a frame and survive reads and writes
    pulse(25'h1 << 16);
    pulse(25'h1 << 23);
    @(posedge clk);
    reg_addr  <= CRES_ADDR_ERR_STATUS;
    reg_wdata <= 32'hFFFF_FFFF;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0000_040D, "held flags");
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0000_040D, "reread flags");
    rd_chk(8'h07, 32'h0000_0000, "unmapped read");
    // An event together with frame start survives the clear
    start_frame(CRES_P_OTHER, 25'h1 << 21);
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0000_0043, "set beats clear");
    start_frame(CRES_P_OTHER, '0);
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0000_0000, "cleared at start");
    // A stop cause ends the frame once; a later one finds it idle
    start_frame(CRES_P_OTHER, '0);
    @(posedge clk);
    ev <= 25'h1 << 10;
    @(negedge clk);
    check("rx_stop first", {31'h0, rx_stop}, 32'h0000_0001);
    @(posedge clk);
    ev <= 25'h1 << 11;
    @(negedge clk);
    check("rx_stop idle", {31'h0, rx_stop}, 32'h0000_0000);
    @(posedge clk);
    ev <= '0;
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0003_0000, "both stop causes");
    // Payload limit: the byte past the limit overflows, the last one allowed does not
    @(posedge clk);
    poll_req_reader <= 1'b1;
    start_frame(CRES_P_LENFIELD, '0);
    repeat (int'(CRES_PAYLOAD_LIMIT)) pulse(25'h1 << 24);
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0000_0000, "payload at limit");
    pulse(25'h1 << 24);
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0000_0010, "payload overflow");
    @(posedge clk);
    poll_req_reader <= 1'b0;
    start_frame(CRES_P_LENFIELD, '0);
    repeat (int'(CRES_PAYLOAD_LIMIT) + 1) pulse(25'h1 << 24);
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0000_0000, "overflow outside poll");
    // A reset in mid-run clears every flag
    pulse(25'h1 << 0);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd_chk(CRES_ADDR_ERR_STATUS, 32'h0000_0000, "mid-run reset");
    give_verdict();
  end
endmodule
